// ---- hw/cfg_port_defs.vh ----
/*
 Constants of the three-wire configuration port: frame layout, register
 count, register reset value. Assumes inclusion by bare name.
*/
`ifndef CFG_PORT_DEFS_VH
`define CFG_PORT_DEFS_VH

`define CFG_REG_COUNT 19
`define CFG_ADDR_W 7
`define CFG_DATA_W 8
`define CFG_FRAME_BITS 16
`define CFG_DIR_POS 5'h07
`define CFG_LAST_POS 5'h0F
`define CFG_CNT_W 5
`define CFG_REG_RESET 8'h00

`endif

// ---- hw/pin_sync3.v ----
/*
 Three-stage synchroniser for one pin, with edge detection on the two
 settled stages. Assumes the pin is asynchronous to clk.
*/
module pin_sync3 #(
	parameter IDLE = 1'b1
) (
	input wire clk,
	input wire sys_rst,
	input wire pinIn,
	output wire level,
	output wire rise,
	output wire fall
);
	reg stage1Reg;
	reg stage2Reg;
	reg stage3Reg;

	// First stage feeds only the second; edges judged on stages two and three
	// Reset to the pin's idle level, else a false edge follows reset
	always @(posedge clk) begin
		if (sys_rst) begin
			stage1Reg <= IDLE;
			stage2Reg <= IDLE;
			stage3Reg <= IDLE;
		end else begin
			stage1Reg <= pinIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
		end
	end

	assign level = stage3Reg;
	assign rise = stage2Reg & ~stage3Reg;
	assign fall = ~stage2Reg & stage3Reg;
endmodule // pin_sync3

// ---- hw/three_wire_config_port.v ----
/*
 Device end of the three-wire serial configuration port: nineteen 8-bit
 configuration registers written and read in 16-bit frames.
 Assumes the serial clock, data and strobe pins are asynchronous to clk
 and that clk runs far faster (250 MHz against at most 12.5 MHz).
*/
`include "cfg_port_defs.vh"

// What this block does
// - Nineteen 8-bit configuration registers, selected by a 7-bit frame address.
// - Each access is one 16-bit frame: address, direction bit, data byte.
// - Eighth bit high means write, low means read-back.
// - Data byte follows, bit seven first, down to bit zero.
// - Data line sampled on each falling edge of the serial clock.
// - Write data reaches the register only after bit zero is sampled.
// - Register contents survive power-down; only supply loss clears them.
// - Writes accepted in any address order.
// - Read frame: device drives addressed register during eight data bits.
// - Every register readable through the same port.
// - Power-down needs just one 16-bit write frame.
// - Clock pin always an undriven input; data pin driven only in read phase.
module three_wire_config_port (
	input wire clk,
	input wire sys_rst,
	input wire cfgSerialClk,
	input wire cfgSerialDataIn,
	output reg cfgSerialDataOut,
	output reg cfgSerialDataOe,
	input wire cfgAddrLatchStrobeN,
	input wire [4:0] regSel,
	output reg [7:0] regValue,
	output reg writeDone,
	output reg [6:0] writeAddr
);
	localparam ST_ADDR = 3'b001;
	localparam ST_WRITE = 3'b010;
	localparam ST_READ = 3'b100;

	wire clkLevel;
	wire clkRise;
	wire clkFall;
	wire dataLevel;
	wire strobeLevel;
	wire strobeFall;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [4:0] bitCnt_reg;
	reg [6:0] cfgFrameAddress_reg;
	reg [7:0] cfgFrameByte_reg;
	reg [7:0] readShift_reg;
	reg [7:0] cfgRegs [0:`CFG_REG_COUNT-1];
	integer i;

	// Address check shared by write and read paths
	function addrValid;
		input [6:0] a;
		begin
			addrValid = (a < `CFG_REG_COUNT);
		end
	endfunction

	// Lookup of a register; unmapped addresses read as zero
	function [7:0] regRead;
		input [6:0] a;
		begin
			regRead = 8'h00;
			if (addrValid(a)) begin
				regRead = cfgRegs[a[4:0]];
			end
		end
	endfunction

	// Serial clock idles low between frames
	pin_sync3 #(.IDLE(1'b0)) syncClk (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinIn(cfgSerialClk),
		.level(clkLevel),
		.rise(clkRise),
		.fall(clkFall)
	);

	pin_sync3 syncData (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinIn(cfgSerialDataIn),
		.level(dataLevel),
		.rise(),
		.fall()
	);

	pin_sync3 syncStrobe (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinIn(cfgAddrLatchStrobeN),
		.level(strobeLevel),
		.rise(),
		.fall(strobeFall)
	);

	// Phase selection from the bit counter at each serial falling edge
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_ADDR: begin
				if (clkFall && bitCnt_reg == `CFG_DIR_POS) begin
					state_next = dataLevel ? ST_WRITE : ST_READ;
				end
			end
			ST_WRITE, ST_READ: begin
				if (clkFall && bitCnt_reg == `CFG_LAST_POS) begin
					state_next = ST_ADDR;
				end
			end
			default: begin
				state_next = ST_ADDR;
			end
		endcase
		if (strobeFall) begin
			state_next = ST_ADDR;
		end
	end

	// Frame shifting; data is sampled only at serial clock falling edges
	always @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= ST_ADDR;
			bitCnt_reg <= 5'h00;
			cfgFrameAddress_reg <= 7'h00;
			cfgFrameByte_reg <= 8'h00;
			readShift_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (strobeFall) begin
				bitCnt_reg <= 5'h00;
			end else if (clkFall) begin
				if (bitCnt_reg == `CFG_LAST_POS) begin
					bitCnt_reg <= 5'h00;
				end else begin
					bitCnt_reg <= bitCnt_reg + 5'h01;
				end
				if (state_reg == ST_ADDR && bitCnt_reg < `CFG_DIR_POS) begin
					cfgFrameAddress_reg <= {cfgFrameAddress_reg[5:0], dataLevel};
				end
				if (state_reg == ST_ADDR && bitCnt_reg == `CFG_DIR_POS) begin
					readShift_reg <= regRead(cfgFrameAddress_reg);
				end
				if (state_reg == ST_WRITE) begin
					cfgFrameByte_reg <= {cfgFrameByte_reg[6:0], dataLevel};
				end
				if (state_reg == ST_READ) begin
					readShift_reg <= {readShift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// Register file; reset here models supply loss only, power-down never clears it
	always @(posedge clk) begin
		if (sys_rst) begin
			for (i = 0; i < `CFG_REG_COUNT; i = i + 1) begin
				cfgRegs[i] <= `CFG_REG_RESET;
			end
		end else if (clkFall && state_reg == ST_WRITE && bitCnt_reg == `CFG_LAST_POS
			&& addrValid(cfgFrameAddress_reg)) begin
			// Any mapped address at any time; one frame is enough for any mode change
			cfgRegs[cfgFrameAddress_reg[4:0]] <= {cfgFrameByte_reg[6:0], dataLevel};
		end
	end

	// Write pulse and readback port for the rest of the chip
	always @(posedge clk) begin
		if (sys_rst) begin
			writeDone <= 1'b0;
			writeAddr <= 7'h00;
			regValue <= 8'h00;
		end else begin
			writeDone <= clkFall && state_reg == ST_WRITE && bitCnt_reg == `CFG_LAST_POS
				&& addrValid(cfgFrameAddress_reg);
			if (clkFall && state_reg == ST_WRITE && bitCnt_reg == `CFG_LAST_POS) begin
				writeAddr <= cfgFrameAddress_reg;
			end
			regValue <= (regSel < `CFG_REG_COUNT) ? cfgRegs[regSel] : 8'h00;
		end
	end

	// Data driver: only in read phase, cut by a strobe fall; off after last bit
	always @(posedge clk) begin
		if (sys_rst) begin
			cfgSerialDataOe <= 1'b0;
			cfgSerialDataOut <= 1'b0;
		end else begin
			cfgSerialDataOe <= (state_next == ST_READ) && !strobeFall;
			cfgSerialDataOut <= (state_next == ST_READ) ? readShift_next_bit(state_reg,
				clkFall, readShift_reg) : 1'b0;
		end
	end

	// Bit presented on the line: on a shifting falling edge the next bit, sh[6], is taken ahead of the shift
	function readShift_next_bit;
		input [2:0] st;
		input fallNow;
		input [7:0] sh;
		begin
			readShift_next_bit = sh[7];
			if (fallNow && st == ST_READ) begin
				readShift_next_bit = sh[6];
			end
		end
	endfunction

	// Clock level and strobe level unused beyond edges; pins never driven here
	wire unusedLevels = clkLevel ^ strobeLevel ^ clkRise;
endmodule // three_wire_config_port

// ---- verification/cfg_host_model.sv ----
/*
 Host model: drives serial clock, strobe and data for one frame.
 Assumes clk at 4 ns; serial period 20 clk, clock idles low.
*/
module cfg_host_model (
	input wire logic clk,
	input wire logic dWire,
	output logic sClk,
	output logic strobeN,
	output logic dOut,
	output logic dOe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: strobe high, data released
	initial begin
		sClk = 0;
		strobeN = 1;
		dOut = 0;
		dOe = 0;
	end
	// Waits n clocks, then lands just after the edge
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One frame; bits set well before each falling edge
	task automatic frame(input logic [6:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] bits;
		bits = {a, wr, d};
		for (int i = 15; i >= 0; i--) begin
			w(8);
			strobeN = i < 8;
			dOe = wr || i > 7;
			dOut = bits[i];
			w(2);
			sClk = 1;
			w(10);
			q = {q[6:0], dWire};
			sClk = 0;
			// Read frame: let go of the wire as soon as the direction bit is taken
			if (i == 8 && !wr) dOe = 0;
		end
		w(8);
		dOe = 0;
	endtask
endmodule // cfg_host_model

// ---- verification/cfg_port_chk.sv ----
/*
 Port checker of the config port. Assumes binding to the design top.
*/
module cfg_port_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cfgSerialClk,
	input wire logic cfgSerialDataIn,
	input wire logic cfgSerialDataOut,
	input wire logic cfgSerialDataOe,
	input wire logic cfgAddrLatchStrobeN,
	input wire logic writeDone,
	input wire logic [6:0] writeAddr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Write completion and data-line ownership
	property p_pulse; writeDone |=> !writeDone; endproperty
	property p_addr; writeDone |-> writeAddr < 7'h13; endproperty
	property p_late; writeDone |-> cfgAddrLatchStrobeN && !cfgSerialClk; endproperty
	property p_quiet; writeDone |-> !cfgSerialDataOe; endproperty
	property p_dir; $rose(cfgSerialDataOe) |-> !$past(cfgSerialDataIn, 8); endproperty
	property p_hold; $rose(cfgSerialDataOe) |-> cfgSerialDataOe[*8]; endproperty
	property p_step; cfgSerialDataOe && $changed(cfgSerialDataOut)
		|-> !cfgSerialClk && $past(!cfgSerialClk, 2); endproperty
	property p_free; $fell(cfgAddrLatchStrobeN) |-> (!cfgSerialDataOe)[*8]; endproperty
	property p_rel; $fell(cfgSerialDataOe) |-> cfgAddrLatchStrobeN && !cfgSerialClk; endproperty
	a_pulse: assert property (p_pulse) else $error("done pulse too long");
	a_addr: assert property (p_addr) else $error("write to no register");
	a_late: assert property (p_late) else $error("write before last bit");
	a_quiet: assert property (p_quiet) else $error("write while driving");
	a_dir: assert property (p_dir) else $error("drive after write bit");
	a_hold: assert property (p_hold) else $error("drive too short");
	a_step: assert property (p_step) else $error("bit changed off edge");
	a_free: assert property (p_free) else $error("drive in address phase");
	a_rel: assert property (p_rel) else $error("release mistimed");
	c_wr: cover property (writeDone);
	c_rd: cover property ($rose(cfgSerialDataOe));
	c_rel: cover property ($fell(cfgSerialDataOe));
endmodule // cfg_port_chk
bind three_wire_config_port cfg_port_chk i_cfg_port_chk (.clk, .sys_rst, .cfgSerialClk,
	.cfgSerialDataIn, .cfgSerialDataOut, .cfgSerialDataOe, .cfgAddrLatchStrobeN,
	.writeDone, .writeAddr);

// ---- verification/tb_top.sv ----
/*
 Bench of the config port with a host model. Assumes pulled-up data wire.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic sys_rst = 1;
	logic sClk, strobeN, hOut, hOe, dOut, dOe, writeDone;
	logic [4:0] regSel = 5'h00;
	logic [7:0] regValue, q;
	logic [6:0] writeAddr;
	int n_mismatch = 0, n_compared = 0, nDone = 0, n0;
	// Wire level from both enables; pull-up when nobody drives
	wire logic dWire = dOe ? dOut : (hOe ? hOut : 1'b1);
	three_wire_config_port i_three_wire_config_port (.clk, .sys_rst, .cfgSerialClk(sClk),
		.cfgSerialDataIn(dWire), .cfgSerialDataOut(dOut), .cfgSerialDataOe(dOe),
		.cfgAddrLatchStrobeN(strobeN), .regSel, .regValue, .writeDone, .writeAddr);
	cfg_host_model i_cfg_host_model (.clk, .dWire, .sClk, .strobeN, .dOut(hOut), .dOe(hOe));
	// Clock, done counter, watchdog
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (writeDone === 1'b1) nDone++;
	initial begin
		#300us;
		n_mismatch++;
		tally_and_finish;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Descending writes, then serial and side read-back of all
	task t_write_read;
		for (int a = 18; a >= 0; a--) begin
			i_cfg_host_model.frame(7'(a), 1, 8'(a * 13 + 7), q);
			chk({1'b0, writeAddr}, 8'(a));
		end
		chk(8'(nDone), 8'h13);
		for (int a = 0; a < 19; a++) begin
			i_cfg_host_model.frame(7'(a), 0, 8'h00, q);
			chk(q, 8'(a * 13 + 7));
			regSel = 5'(a);
			repeat (2) @(posedge clk);
			#1;
			chk(regValue, 8'(a * 13 + 7));
		end
	endtask
	// Writes past the map must not alias a register
	task t_unmapped;
		n0 = nDone;
		i_cfg_host_model.frame(7'h13, 1, 8'hA5, q);
		i_cfg_host_model.frame(7'h23, 1, 8'h3C, q);
		chk(8'(nDone - n0), 8'h00);
		i_cfg_host_model.frame(7'h03, 0, 8'h00, q);
		chk(q, 8'h2E);
		i_cfg_host_model.frame(7'h13, 0, 8'h00, q);
		chk(q, 8'h00);
	endtask
	task tally_and_finish;
		$display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 0;
		repeat (4) @(posedge clk);
		#1;
		i_cfg_host_model.frame(7'h05, 0, 8'h00, q);
		chk(q, 8'h00);
		t_write_read;
		t_unmapped;
		tally_and_finish;
	end
endmodule // tb_top
